// File: hdl/pcsp_pkg.sv
// shared constants of the pcm channel serial port
package pcsp_pkg;

	// channel word and bit counting
	localparam int unsigned CHAN_BITS    = 8;
	localparam logic [3:0]  BIT_CNT_ZERO = 4'h0;
	localparam logic [3:0]  BIT_CNT_LAST = 4'h7;
	localparam logic [3:0]  BIT_CNT_FULL = 4'h8;

	// word sent when software has queued nothing
	localparam logic [7:0]  TX_IDLE_CODE = 8'hff;

	// buffering
	localparam int unsigned FIFO_DEPTH   = 16;

	// reset values of the pin drivers
	localparam logic        OE_N_RESET   = 1'h1;
	localparam logic        DOUT_RESET   = 1'h0;

endpackage : pcsp_pkg

// File: hdl/pcsp_sync.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module pcsp_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset of the receiving domain
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// level from another domain and its synchronised copy
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} pcsp_sync_s;

	pcsp_sync_s sy_ff;
	pcsp_sync_s nxt_sy;

	always_comb begin
		nxt_sy      = sy_ff;
		nxt_sy.meta = i_async;
		nxt_sy.held = sy_ff.meta;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sy_ff <= '0;
		end else begin
			sy_ff <= nxt_sy;
		end
	end

	assign o_sync = sy_ff.held;

endmodule : pcsp_sync

`default_nettype wire

// File: hdl/pcsp_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module pcsp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// filling side
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	// draining side
	output logic      [WIDTH-1:0] o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} pcsp_fifo_s;

	pcsp_fifo_s ff_ff;
	pcsp_fifo_s nxt_ff;
	logic       push;
	logic       pop;

	assign o_in_ready  = (ff_ff.cnt != CNT_FULL);
	assign o_out_valid = (ff_ff.cnt != '0);
	assign o_out_data  = ff_ff.mem[ff_ff.rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		nxt_ff = ff_ff;
		if (push) begin
			nxt_ff.mem[ff_ff.wr] = i_in_data;
			nxt_ff.wr            = (ff_ff.wr == PTR_LAST) ? '0 : ff_ff.wr + 1'b1;
		end
		if (pop) begin
			nxt_ff.rd = (ff_ff.rd == PTR_LAST) ? '0 : ff_ff.rd + 1'b1;
		end
		if (push && !pop) begin
			nxt_ff.cnt = ff_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_ff.cnt = ff_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ff_ff <= '0;
		end else begin
			ff_ff <= nxt_ff;
		end
	end

endmodule : pcsp_fifo

`default_nettype wire

// File: hdl/pcsp_port.sv
// pcm channel serial port: link shifter on the bit clock, fifos on the core clock
`timescale 1ns/1ps
`default_nettype none

module pcsp_port #(
	parameter int unsigned FIFO_DEPTH = pcsp_pkg::FIFO_DEPTH,
	parameter logic [7:0]  TX_IDLE    = pcsp_pkg::TX_IDLE_CODE
) (
	// core clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	// link pins; bit clock in strobe mode, quad clock in backplane mode
	input  wire logic       i_serial_bit_clock,
	input  wire logic       i_main_clock_input,
	input  wire logic       i_timeslot_strobe_or_frame_pulse,
	input  wire logic       i_din,
	output logic            o_dout,
	output logic            o_dout_oe_n,
	// mode straps
	input  wire logic       i_strobe_serial_mode,
	input  wire logic       i_async_clock_mode,
	// transmit words from the user
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_tx_ready,
	// receive words to the user
	output logic      [7:0] o_rx_data,
	output logic            o_rx_valid,
	input  wire logic       i_rx_ready,
	// status pulses
	output logic            o_rx_overrun,
	output logic            o_tx_underrun,
	output logic            o_phone_clk_tick
);

	// ---------------- link domain ----------------
	typedef struct packed {
		logic [1:0] live;
		logic       in_slot;
		logic       ph;
		logic [3:0] tx_cnt;
		logic [3:0] rx_cnt;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [7:0] rx_word;
		logic       rx_tgl;
		logic       ack_tgl;
		logic       dout;
		logic       oe_n;
	} pcsp_link_s;

	pcsp_link_s lk_ff;
	pcsp_link_s nxt_lk;
	logic       din_fall_ff;
	logic       stb_fall_ff;
	logic       lk_smode;
	logic [7:0] tx_word;
	logic [7:0] lk_cur;
	logic [7:0] lk_rx_next;

	pcsp_sync #(
		.WIDTH (1)
	) u_lk_mode_sync (
		.i_clk   (i_serial_bit_clock),
		.i_rst   (i_rst),
		.i_async (i_strobe_serial_mode),
		.o_sync  (lk_smode)
	);

	// falling edge samples of data and strobe
	always_ff @(negedge i_serial_bit_clock or posedge i_rst) begin
		if (i_rst) begin
			din_fall_ff <= 1'h0;
			stb_fall_ff <= 1'h0;
		end else begin
			din_fall_ff <= i_din;
			stb_fall_ff <= i_timeslot_strobe_or_frame_pulse;
		end
	end

	// first bit comes from the core word, later bits from the shifter
	assign lk_cur     = (lk_ff.tx_cnt == pcsp_pkg::BIT_CNT_ZERO) ? tx_word : lk_ff.tx_sh;
	assign lk_rx_next = {lk_ff.rx_sh[6:0], din_fall_ff};

	always_comb begin
		nxt_lk      = lk_ff;
		nxt_lk.live = {lk_ff.live[0], 1'h1}; // mode strap and frame pulse samples settle first
		if (lk_smode) begin
			nxt_lk.in_slot = 1'h0;
			nxt_lk.ph      = 1'h0;
			if (stb_fall_ff && (lk_ff.rx_cnt != pcsp_pkg::BIT_CNT_FULL)) begin
				nxt_lk.rx_sh  = lk_rx_next;
				nxt_lk.rx_cnt = lk_ff.rx_cnt + 4'h1;
				if (lk_ff.rx_cnt == pcsp_pkg::BIT_CNT_LAST) begin
					nxt_lk.rx_word = lk_rx_next;
					nxt_lk.rx_tgl  = ~lk_ff.rx_tgl;
				end
			end else if (!stb_fall_ff) begin
				nxt_lk.rx_cnt = pcsp_pkg::BIT_CNT_ZERO;
			end
			if (i_timeslot_strobe_or_frame_pulse && (lk_ff.tx_cnt != pcsp_pkg::BIT_CNT_FULL)) begin
				nxt_lk.dout   = lk_cur[7];
				nxt_lk.tx_sh  = {lk_cur[6:0], 1'h0};
				nxt_lk.oe_n   = 1'h0;
				nxt_lk.tx_cnt = lk_ff.tx_cnt + 4'h1;
				if (lk_ff.tx_cnt == pcsp_pkg::BIT_CNT_ZERO) begin
					nxt_lk.ack_tgl = ~lk_ff.ack_tgl;
				end
			end else begin
				nxt_lk.oe_n = 1'h1;
				if (!i_timeslot_strobe_or_frame_pulse) begin
					nxt_lk.tx_cnt = pcsp_pkg::BIT_CNT_ZERO;
				end
			end
		end else if (!stb_fall_ff && lk_ff.live[1]) begin
			nxt_lk.in_slot = 1'h1;
			nxt_lk.ph      = 1'h0;
			nxt_lk.dout    = tx_word[7];
			nxt_lk.tx_sh   = {tx_word[6:0], 1'h0};
			nxt_lk.tx_cnt  = 4'h1;
			nxt_lk.rx_cnt  = pcsp_pkg::BIT_CNT_ZERO;
			nxt_lk.oe_n    = 1'h0;
			nxt_lk.ack_tgl = ~lk_ff.ack_tgl;
		end else if (lk_ff.in_slot) begin
			nxt_lk.ph = ~lk_ff.ph;
			if (lk_ff.ph) begin
				nxt_lk.rx_sh  = lk_rx_next;
				nxt_lk.rx_cnt = lk_ff.rx_cnt + 4'h1;
				if (lk_ff.rx_cnt == pcsp_pkg::BIT_CNT_LAST) begin
					nxt_lk.rx_word = lk_rx_next;
					nxt_lk.rx_tgl  = ~lk_ff.rx_tgl;
					nxt_lk.in_slot = 1'h0;
				end
				if (lk_ff.tx_cnt != pcsp_pkg::BIT_CNT_FULL) begin
					nxt_lk.dout   = lk_ff.tx_sh[7];
					nxt_lk.tx_sh  = {lk_ff.tx_sh[6:0], 1'h0};
					nxt_lk.tx_cnt = lk_ff.tx_cnt + 4'h1;
				end else begin
					nxt_lk.oe_n = 1'h1;
				end
			end
		end else begin
			nxt_lk.oe_n = 1'h1;
		end
	end

	always_ff @(posedge i_serial_bit_clock or posedge i_rst) begin
		if (i_rst) begin
			lk_ff      <= '0;
			lk_ff.dout <= pcsp_pkg::DOUT_RESET;
			lk_ff.oe_n <= pcsp_pkg::OE_N_RESET;
		end else begin
			lk_ff <= nxt_lk;
		end
	end

	assign o_dout      = lk_ff.dout;
	assign o_dout_oe_n = lk_ff.oe_n;

	// ---------------- core domain ----------------
	typedef struct packed {
		logic       rx_t3;
		logic       ak_t3;
		logic       bc_t3;
		logic       mc_t3;
		logic [7:0] tx_word;
		logic       overrun;
		logic       underrun;
		logic       tick;
	} pcsp_core_s;

	pcsp_core_s co_ff;
	pcsp_core_s nxt_co;
	logic [5:0] co_sync;
	logic       rx_evt;
	logic       ack_evt;
	logic       tick_sel;
	logic       tick_prev;
	logic       rxf_in_ready;
	logic [7:0] txf_data;
	logic       txf_valid;

	pcsp_sync #(
		.WIDTH (6)
	) u_core_sync (
		.i_clk   (i_core_clk),
		.i_rst   (i_rst),
		.i_async ({lk_ff.rx_tgl, lk_ff.ack_tgl, i_serial_bit_clock, i_main_clock_input,
			i_strobe_serial_mode, i_async_clock_mode}),
		.o_sync  (co_sync)
	);

	assign rx_evt  = co_sync[5] ^ co_ff.rx_t3;
	assign ack_evt = co_sync[4] ^ co_ff.ak_t3;

	// bit clock times phone functions; master clock when asynchronous in strobe mode
	assign tick_sel  = (co_sync[1] && co_sync[0]) ? co_sync[2] : co_sync[3];
	assign tick_prev = (co_sync[1] && co_sync[0]) ? co_ff.mc_t3 : co_ff.bc_t3;

	// rx word stays stable a whole frame after its toggle
	pcsp_fifo #(
		.WIDTH (pcsp_pkg::CHAN_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.i_clk       (i_core_clk),
		.i_rst       (i_rst),
		.i_in_data   (lk_ff.rx_word),
		.i_in_valid  (rx_evt),
		.o_in_ready  (rxf_in_ready),
		.o_out_data  (o_rx_data),
		.o_out_valid (o_rx_valid),
		.i_out_ready (i_rx_ready)
	);

	// one word drained per frame when the link takes a word
	pcsp_fifo #(
		.WIDTH (pcsp_pkg::CHAN_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk       (i_core_clk),
		.i_rst       (i_rst),
		.i_in_data   (i_tx_data),
		.i_in_valid  (i_tx_valid),
		.o_in_ready  (o_tx_ready),
		.o_out_data  (txf_data),
		.o_out_valid (txf_valid),
		.i_out_ready (ack_evt)
	);

	always_comb begin
		nxt_co          = co_ff;
		nxt_co.rx_t3    = co_sync[5];
		nxt_co.ak_t3    = co_sync[4];
		nxt_co.bc_t3    = co_sync[3];
		nxt_co.mc_t3    = co_sync[2];
		nxt_co.tick     = tick_sel && !tick_prev;
		nxt_co.overrun  = rx_evt && !rxf_in_ready;
		nxt_co.underrun = ack_evt && !txf_valid;
		// next slot word staged after the link took this one
		if (ack_evt) begin
			nxt_co.tx_word = txf_valid ? txf_data : TX_IDLE;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			co_ff         <= '0;
			co_ff.tx_word <= pcsp_pkg::TX_IDLE_CODE;
		end else begin
			co_ff <= nxt_co;
		end
	end

	// held a frame, read by the link only at slot start
	assign tx_word          = co_ff.tx_word;
	assign o_rx_overrun     = co_ff.overrun;
	assign o_tx_underrun    = co_ff.underrun;
	assign o_phone_clk_tick = co_ff.tick;

	// ---------------- checks, link domain ----------------
	sequence s_bp_drive;
		(!o_dout_oe_n)[*8] ##1 (!o_dout_oe_n)[*8];
	endsequence

	property p_release_outside;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(lk_smode && !i_timeslot_strobe_or_frame_pulse) |=> o_dout_oe_n;
	endproperty
	a_release_outside: assert property (p_release_outside) else $error("output driven outside slot");

	property p_first_bit;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(lk_smode && $rose(i_timeslot_strobe_or_frame_pulse) && lk_ff.tx_cnt == 4'h0)
			|=> (!o_dout_oe_n && o_dout == $past(tx_word[7]));
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first bit not msb of word");

	property p_eight_bits;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(lk_smode && !o_dout_oe_n)[*8] |=> o_dout_oe_n;
	endproperty
	a_eight_bits: assert property (p_eight_bits) else $error("more than eight bits driven");

	property p_rx_word;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(lk_smode && stb_fall_ff && lk_ff.rx_cnt == 4'h7)
			|=> (lk_ff.rx_tgl != $past(lk_ff.rx_tgl) && lk_ff.rx_word[0] == $past(din_fall_ff));
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("eighth sample not delivered");
	property p_bp_slot;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(lk_ff.live[1] && !lk_smode && !stb_fall_ff) |-> ##17 o_dout_oe_n;
	endproperty
	a_bp_slot: assert property (p_bp_slot) else $error("backplane slot not sixteen clocks");
	property p_bp_drive;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(lk_ff.live[1] && !lk_smode && !stb_fall_ff) |=> s_bp_drive;
	endproperty
	a_bp_drive: assert property (p_bp_drive) else $error("backplane slot released early");
	property p_bp_half;
		@(posedge i_serial_bit_clock) disable iff (i_rst)
		(!lk_smode && stb_fall_ff && lk_ff.in_slot && !lk_ff.ph) |=> $stable(o_dout);
	endproperty
	a_bp_half: assert property (p_bp_half) else $error("bit changed mid bit");

	// ---------------- checks, core domain ----------------
	property p_tx_stage;
		@(posedge i_core_clk) disable iff (i_rst)
		ack_evt |=> co_ff.tx_word == ($past(txf_valid) ? $past(txf_data) : TX_IDLE);
	endproperty
	a_tx_stage: assert property (p_tx_stage) else $error("next slot word not staged");

	property p_tick_pulse;
		@(posedge i_core_clk) disable iff (i_rst)
		o_phone_clk_tick |=> !o_phone_clk_tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("clock tick longer than a cycle");

endmodule : pcsp_port

`default_nettype wire

// File: sim/pcsp_l1_model.sv
// line interface model: link clock, slot strobe or frame pulse, serial data
`timescale 1ns/1ps
`default_nettype none

module pcsp_l1_model (
	// mode of the port
	input  wire logic i_strobe_mode,
	// link pins
	output logic      o_bit_clk,
	output logic      o_strobe,
	output logic      o_din,
	input  wire logic i_dout,
	input  wire logic i_dout_oe_n
);
	logic in_slot;

	initial begin
		o_bit_clk = 1'b0;
		o_strobe  = 1'b0;
		o_din     = 1'b0;
		in_slot   = 1'b0;
	end

	// free running bit or quad clock
	always #80 o_bit_clk = ~o_bit_clk;

	// idle strobe low, idle frame pulse high
	always @(i_strobe_mode) if (!in_slot) o_strobe = ~i_strobe_mode;

	// released data line keeps changing
	always @(posedge o_bit_clk) if (!in_slot) o_din <= ~o_din;

	task automatic frame(input logic [7:0] w, input int extra, output logic [7:0] got, output logic ok);
		int k;
		ok = 1'b1;
		@(negedge o_bit_clk);
		#1;
		in_slot = 1'b1;
		if (i_strobe_mode) begin
			o_strobe = 1'b1;
		end else begin
			// frame pulse one quad clock low
			@(posedge o_bit_clk);
			#1 o_strobe = 1'b0;
			@(posedge o_bit_clk);
			#1 o_strobe = 1'b1;
		end
		for (k = 7; k >= 0; k--) begin
			if (i_strobe_mode) begin
				@(posedge o_bit_clk);
				#1;
			end
			o_din = w[k];
			if (!i_strobe_mode) begin
				@(negedge o_bit_clk);
				@(posedge o_bit_clk);
			end
			@(negedge o_bit_clk);
			got[k] = i_dout;
			ok &= (i_dout_oe_n === 1'b0);
			if (!i_strobe_mode) begin
				@(posedge o_bit_clk);
				#1;
			end
		end
		repeat (extra) begin
			@(negedge o_bit_clk);
			ok &= (i_dout_oe_n === 1'b1);
		end
		#1 o_strobe = ~i_strobe_mode;
		@(negedge o_bit_clk);
		ok &= (i_dout_oe_n === 1'b1);
		in_slot = 1'b0;
	endtask : frame
endmodule : pcsp_l1_model
`default_nettype wire

// File: sim/pcsp_port_tb_top.sv
// self-checking bench of the pcm channel serial port
`timescale 1ns/1ps
`default_nettype none

module pcsp_port_tb_top;
	typedef struct packed {
		logic       sm;
		logic [7:0] tx;
		logic [7:0] rx;
	} pcsp_row_s;

	logic       clk, rst, mclk, sm, am, bclk, stb, din, dout, oe_n;
	logic       tx_valid, tx_ready, rx_valid, rx_ready, ovr_p, und_p, tick, ok;
	logic [7:0] tx_data, rx_data, got, prev;
	int         failures, checked, ovr, und, ticks, i;
	pcsp_row_s  rows [6];

	pcsp_port DUT (
		.i_core_clk(clk), .i_rst(rst), .i_serial_bit_clock(bclk), .i_main_clock_input(mclk),
		.i_timeslot_strobe_or_frame_pulse(stb), .i_din(din), .o_dout(dout), .o_dout_oe_n(oe_n),
		.i_strobe_serial_mode(sm), .i_async_clock_mode(am), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
		.o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
		.o_rx_overrun(ovr_p), .o_tx_underrun(und_p), .o_phone_clk_tick(tick)
	);

	pcsp_l1_model l1 (
		.i_strobe_mode(sm), .o_bit_clk(bclk), .o_strobe(stb), .o_din(din), .i_dout(dout), .i_dout_oe_n(oe_n)
	);

	initial begin
		clk      = 1'b0;
		mclk     = 1'b0;
		rst      = 1'b1;
		sm       = 1'b1;
		am       = 1'b0;
		tx_data  = 8'h00;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
	end

	always #20 clk = ~clk;
	always #125 mclk = ~mclk;

	always @(negedge clk) begin
		if (ovr_p === 1'b1) ovr++;
		if (und_p === 1'b1) und++;
		if (tick === 1'b1) ticks++;
	end

	task automatic tally_and_finish;
		if (failures == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic bail;
		chk(8'h00, 8'h01);
		tally_and_finish();
	endtask : bail

	always @(negedge bclk) if (l1.in_slot === 1'b0 && rst === 1'b0) chk({7'h00, oe_n}, 8'h01);

	task automatic do_reset(input logic m);
		@(negedge clk);
		rst = 1'b1;
		sm  = m;
		am  = 1'b0;
		repeat (8) @(negedge clk);
		chk({5'h00, oe_n, tx_ready, rx_valid}, 8'h06);
		rst = 1'b0;
		ovr = 0;
		und = 0;
		repeat (5) @(posedge bclk);
		@(negedge clk);
	endtask : do_reset

	task automatic push(input logic [7:0] d);
		int n;
		@(negedge clk);
		tx_data  = d;
		tx_valid = 1'b1;
		for (n = 0; n < 50 && tx_ready !== 1'b1; n++) @(negedge clk);
		if (n == 50) bail();
		@(negedge clk);
		tx_valid = 1'b0;
		repeat (20) @(negedge clk);
	endtask : push

	task automatic pop_chk(input logic [7:0] e);
		int n;
		for (n = 0; n < 50 && rx_valid !== 1'b1; n++) @(negedge clk);
		if (n == 50) bail();
		chk(rx_data, e);
		rx_ready = 1'b1;
		@(negedge clk);
		rx_ready = 1'b0;
		@(negedge clk);
	endtask : pop_chk

	task automatic xfer(input logic [7:0] w, input int extra, input logic [7:0] e);
		l1.frame(w, extra, got, ok);
		chk(got, e);
		chk({7'h00, ok}, 8'h01);
		repeat (10) @(negedge clk);
	endtask : xfer

	task automatic tick_chk(input int lo, input int hi);
		@(negedge clk);
		ticks = 0;
		repeat (100) @(negedge clk);
		checked++;
		if (ticks < lo || ticks > hi) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, ticks, lo);
		end
	endtask : tick_chk

	initial begin
		rows[0] = {1'b1, 8'h5a, 8'hc3};
		rows[1] = {1'b1, 8'h01, 8'h80};
		rows[2] = {1'b1, 8'hfe, 8'h7f};
		rows[3] = {1'b0, 8'ha5, 8'h3c};
		rows[4] = {1'b0, 8'h80, 8'h01};
		rows[5] = {1'b0, 8'h7e, 8'he7};
		for (i = 0; i < 6; i++) begin
			if (i == 0 || rows[i].sm !== rows[i-1].sm) begin
				do_reset(rows[i].sm);
				prev = 8'hff;
			end
			push(rows[i].tx);
			xfer(rows[i].rx, 0, prev);
			pop_chk(rows[i].rx);
			prev = rows[i].tx;
		end
		tick_chk(24, 26);
		do_reset(1'b1);
		tick_chk(24, 26);
		@(negedge clk);
		am = 1'b1;
		repeat (10) @(negedge clk);
		tick_chk(15, 17);
		// fill tx fifo, stall rx side until overrun
		do_reset(1'b1);
		for (i = 0; i < 16; i++) push(8'h10 + i[7:0]);
		chk({7'h00, tx_ready}, 8'h00);
		for (i = 0; i < 17; i++) xfer(8'h20 + i[7:0], 0, (i == 0) ? 8'hff : 8'h0f + i[7:0]);
		chk({6'h00, ovr == 1, und == 1}, 8'h03);
		for (i = 0; i < 16; i++) pop_chk(8'h20 + i[7:0]);
		chk({7'h00, tx_ready}, 8'h01);
		// strobe held two clocks past the slot
		xfer(8'h99, 2, 8'hff);
		pop_chk(8'h99);
		chk({7'h00, und == 2}, 8'h01);
		tally_and_finish();
	end
endmodule : pcsp_port_tb_top
`default_nettype wire
